//--- design/inductive_readout.sv
// Result and status readout of the inductance-to-digital converter
//
// Chosen here: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module inductive_readout (
  input  wire logic         clock,
  input  wire logic         rst,
  sensor_link_if.device     link,
  input  wire logic         sensor_tick,
  input  wire logic         osc_stalled,
  input  wire logic         below_floor,
  input  wire logic         above_ceiling,
  input  wire logic [7:0]   raw_impedance,
  output logic      [7:0]   floor_code,
  output logic      [7:0]   ceiling_code,
  output logic      [1:0]   amplitude,
  output logic              converting
);
  import inductive_pkg::*;

  logic [7:0]  ceiling_q;
  logic [7:0]  floor_q;
  logic [7:0]  config_q;
  logic [7:0]  thr_hi_q;
  logic [7:0]  thr_lo_q;
  logic [2:0]  mode_q;
  logic        power_q;
  logic [11:0] tick_cnt_q;
  logic [23:0] clk_cnt_q;
  logic        conv_done;
  logic [7:0]  clipped;
  logic [7:0]  new_result_q;
  logic [23:0] new_count_q;
  logic [7:0]  result_q;
  logic [23:0] count_q;
  logic        fresh_q;
  logic        cmp_q;
  logic        wake_hit_q;
  logic        osc_q;
  logic [2:0]  ev_q;
  logic [2:0]  ev_en_q;
  logic [2:0]  ev_set;
  logic [2:0]  ev_clr;
  logic [7:0]  status;
  logic [7:0]  rdata_q;
  logic        result_read;
  logic        cmp_next;

  assign result_read = link.rd && (link.addr == RESULT_ADDR);

  // Configuration registers
  always_ff @(posedge clock) begin
    if (rst) begin
      ceiling_q <= CEILING_RST;
      floor_q   <= FLOOR_RST;
      config_q  <= CONFIG_RST;
      thr_hi_q  <= THR_HI_RST;
      thr_lo_q  <= THR_LO_RST;
      mode_q    <= MODE_RST[2:0];
      power_q   <= POWER_RST[POWER_BIT];
    end else if (link.wr) begin
      unique case (link.addr)
        CEILING_ADDR: ceiling_q <= link.wdata;
        FLOOR_ADDR:   floor_q   <= link.wdata;
        CONFIG_ADDR:  config_q  <= link.wdata;
        THR_HI_ADDR:  thr_hi_q  <= link.wdata;
        THR_LO_ADDR:  thr_lo_q  <= link.wdata;
        MODE_ADDR:    mode_q    <= link.wdata[2:0];
        POWER_ADDR:   power_q   <= link.wdata[POWER_BIT];
        default: ;
      endcase
    end
  end

  assign floor_code   = floor_q;
  assign ceiling_code = ceiling_q;
  assign amplitude    = config_q[4:3];
  assign converting   = power_q;

  // Conversion window counts sensor ticks and system clocks
  assign conv_done = power_q && sensor_tick &&
      (tick_cnt_q + 12'h001 >= ticks_per_result(config_q[2:0]));

  always_ff @(posedge clock) begin
    if (rst || !power_q) begin
      tick_cnt_q <= 12'h000;
      clk_cnt_q  <= 24'h000000;
    end else if (conv_done) begin
      tick_cnt_q <= 12'h000;
      clk_cnt_q  <= 24'h000001;
    end else begin
      if (sensor_tick) begin
        tick_cnt_q <= tick_cnt_q + 12'h001;
      end
      clk_cnt_q <= clk_cnt_q + 24'h000001;
    end
  end

  // Front end flags out-of-range impedance
  always_comb begin
    if (below_floor) begin
      clipped = 8'h00;
    end else if (above_ceiling) begin
      clipped = 8'hff;
    end else begin
      clipped = raw_impedance;
    end
  end

  // Latest conversion; its result reads back directly at RESULT_ADDR, its count is not yet visible to the host
  always_ff @(posedge clock) begin
    if (rst) begin
      new_result_q <= 8'h00;
      new_count_q  <= 24'h000000;
    end else if (conv_done) begin
      new_result_q <= clipped;
      new_count_q  <= clk_cnt_q;
    end
  end

  // Visible registers move only on impedance reads
  always_ff @(posedge clock) begin
    if (rst) begin
      result_q <= 8'h00;
      count_q  <= 24'h000000;
    end else if (result_read) begin
      result_q <= new_result_q;
      count_q  <= new_count_q;
    end
  end

  // Fresh result flag; a completing conversion beats the read
  always_ff @(posedge clock) begin
    if (rst) begin
      fresh_q <= 1'b0;
    end else if (conv_done) begin
      fresh_q <= 1'b1;
    end else if (result_read) begin
      fresh_q <= 1'b0;
    end
  end

  // Comparator holds between thresholds
  always_comb begin
    cmp_next = cmp_q;
    if (clipped < thr_lo_q) begin
      cmp_next = 1'b1;
    end else if (clipped > thr_hi_q) begin
      cmp_next = 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      cmp_q <= 1'b0;
    end else if (conv_done) begin
      cmp_q <= cmp_next;
    end
  end

  // Wake-up latches while enabled
  always_ff @(posedge clock) begin
    if (rst || mode_q != MODE_WAKE) begin
      wake_hit_q <= 1'b0;
    end else if (conv_done && clipped > thr_hi_q) begin
      wake_hit_q <= 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      osc_q <= 1'b0;
    end else begin
      osc_q <= osc_stalled;
    end
  end

  always_comb begin
    status             = 8'h00;
    status[ST_OSC]     = osc_q;
    status[ST_READY_N] = !fresh_q;
    status[ST_WAKE_N]  = !wake_hit_q;
    status[ST_CMP]     = cmp_q;
  end

  // Event flags; set wins over clear
  always_comb begin
    ev_set          = 3'h0;
    ev_set[EV_CONV] = conv_done;
    ev_set[EV_CMP]  = conv_done && (cmp_next != cmp_q);
    ev_set[EV_OSC]  = osc_stalled && !osc_q;
    ev_clr          = 3'h0;
    if (link.wr && link.addr == EV_CLR_ADDR) begin
      ev_clr = link.wdata[2:0];
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      ev_q <= 3'h0;
    end else begin
      ev_q <= (ev_q & ~ev_clr) | ev_set;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      ev_en_q <= 3'h0;
    end else if (link.wr && link.addr == EV_EN_ADDR) begin
      ev_en_q <= link.wdata[2:0];
    end
  end

  assign link.attention = |(ev_q & ev_en_q);

  // Read data, one cycle after the strobe
  always_ff @(posedge clock) begin
    if (rst) begin
      rdata_q <= 8'h00;
    end else if (link.rd) begin
      unique case (link.addr)
        CEILING_ADDR: rdata_q <= ceiling_q;
        FLOOR_ADDR:   rdata_q <= floor_q;
        CONFIG_ADDR:  rdata_q <= config_q;
        THR_HI_ADDR:  rdata_q <= thr_hi_q;
        THR_LO_ADDR:  rdata_q <= thr_lo_q;
        MODE_ADDR:    rdata_q <= {5'h00, mode_q};
        POWER_ADDR:   rdata_q <= {7'h00, power_q};
        STATUS_ADDR:  rdata_q <= status;
        RESULT_ADDR:  rdata_q <= new_result_q;
        CNT_LO_ADDR:  rdata_q <= count_q[7:0];
        CNT_MID_ADDR: rdata_q <= count_q[15:8];
        CNT_HI_ADDR:  rdata_q <= count_q[23:16];
        EV_STAT_ADDR: rdata_q <= {5'h00, ev_q};
        EV_EN_ADDR:   rdata_q <= {5'h00, ev_en_q};
        default:      rdata_q <= 8'h00;
      endcase
    end
  end

  assign link.rdata = rdata_q;
endmodule : inductive_readout
`default_nettype wire

//--- design/inductive_pkg.sv
// Shared constants for the inductive readout device and its host controller
package inductive_pkg;
  localparam int unsigned AW = 8;
  localparam int unsigned DW = 8;

  // Device register offsets
  localparam logic [7:0] CEILING_ADDR = 8'h01;
  localparam logic [7:0] FLOOR_ADDR   = 8'h02;
  localparam logic [7:0] CONFIG_ADDR  = 8'h04;
  localparam logic [7:0] THR_HI_ADDR  = 8'h07;
  localparam logic [7:0] THR_LO_ADDR  = 8'h09;
  localparam logic [7:0] MODE_ADDR    = 8'h0a;
  localparam logic [7:0] POWER_ADDR   = 8'h0b;
  localparam logic [7:0] STATUS_ADDR  = 8'h20;
  localparam logic [7:0] RESULT_ADDR  = 8'h22;
  localparam logic [7:0] CNT_LO_ADDR  = 8'h23;
  localparam logic [7:0] CNT_MID_ADDR = 8'h24;
  localparam logic [7:0] CNT_HI_ADDR  = 8'h25;
  localparam logic [7:0] EV_STAT_ADDR = 8'h28;
  localparam logic [7:0] EV_EN_ADDR   = 8'h29;
  localparam logic [7:0] EV_CLR_ADDR  = 8'h2a;

  // Device reset values
  localparam logic [7:0] CEILING_RST = 8'h00;
  localparam logic [7:0] FLOOR_RST   = 8'h14;
  localparam logic [7:0] CONFIG_RST  = 8'h1b;
  localparam logic [7:0] THR_HI_RST  = 8'hff;
  localparam logic [7:0] THR_LO_RST  = 8'h00;
  localparam logic [7:0] MODE_RST    = 8'h00;
  localparam logic [7:0] POWER_RST   = 8'h00;

  // Field positions and codes
  localparam int unsigned ST_OSC     = 7;
  localparam int unsigned ST_READY_N = 6;
  localparam int unsigned ST_WAKE_N  = 5;
  localparam int unsigned ST_CMP     = 4;
  localparam int unsigned POWER_BIT  = 0;
  localparam logic [2:0]  MODE_WAKE  = 3'h1;
  localparam logic [7:0]  CODE_MAX   = 8'h3f;
  localparam logic [11:0] RESP_BASE  = 12'h0c0;
  localparam logic [11:0] RESP_DIV   = 12'h003;
  localparam int unsigned EV_CONV    = 0;
  localparam int unsigned EV_CMP     = 1;
  localparam int unsigned EV_OSC     = 2;

  // Host controller registers
  localparam logic [7:0] H_ADDR_ADDR  = 8'h00;
  localparam logic [7:0] H_WDATA_ADDR = 8'h01;
  localparam logic [7:0] H_CMD_ADDR   = 8'h02;
  localparam logic [7:0] H_STAT_ADDR  = 8'h03;
  localparam logic [7:0] H_RDATA_ADDR = 8'h04;
  localparam logic [7:0] H_EV_ADDR    = 8'h05;
  localparam logic [7:0] H_EN_ADDR    = 8'h06;
  localparam logic [7:0] H_CLR_ADDR   = 8'h07;
  localparam int unsigned CMD_WRITE   = 0;
  localparam int unsigned CMD_READ    = 1;
  localparam int unsigned HEV_DONE    = 0;
  localparam int unsigned HEV_REFUSED = 1;
  localparam int unsigned HEV_ATTN    = 2;

  // Sensor ticks per conversion: response time divided by three
  // Response time reaches 6144, so it needs 13 bits before the divide
  function automatic logic [11:0] ticks_per_result(input logic [2:0] code);
    logic [13:0] resp;
    logic [13:0] ticks;
    resp  = (code < 3'h2) ? {2'b00, RESP_BASE} :
            {2'b00, RESP_BASE} << (code - 3'h2);
    ticks = resp / {2'b00, RESP_DIV};
    return ticks[11:0];
  endfunction : ticks_per_result
endpackage : inductive_pkg

//--- design/sensor_link_if.sv
// Register link between host controller and readout device
`timescale 1ns/1ps
`default_nettype none
interface sensor_link_if;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic       wr;
  logic       rd;
  logic [7:0] rdata;
  logic       attention;
  modport device (input addr, wdata, wr, rd, output rdata, attention);
  modport host   (output addr, wdata, wr, rd, input rdata, attention);
endinterface : sensor_link_if
`default_nettype wire

//--- design/inductive_host.sv
// Host controller issuing register transfers to the readout device
`timescale 1ns/1ps
`default_nettype none
module inductive_host (
  input  wire logic         clock,
  input  wire logic         rst,
  sensor_link_if.host       link,
  input  wire logic [7:0]   addr,
  input  wire logic [7:0]   wdata,
  input  wire logic         wr,
  input  wire logic         rd,
  output logic      [7:0]   rdata,
  output logic              irq
);
  import inductive_pkg::*;

  typedef enum logic [1:0] {
    IDLE    = 2'b00,
    ISSUE   = 2'b01,
    CAPTURE = 2'b10
  } xfer_e;

  xfer_e      state_q;
  logic [7:0] tgt_addr_q;
  logic [7:0] tgt_wdata_q;
  logic       is_read_q;
  logic       floor_set_q;
  logic       refused_q;
  logic [7:0] result_q;
  logic [2:0] ev_q;
  logic [2:0] ev_en_q;
  logic [2:0] ev_set;
  logic [2:0] ev_clr;
  logic [7:0] rdata_q;
  logic       go_write;
  logic       go_read;
  logic       bad_code;
  logic       early_power;
  logic       refuse;

  assign go_write = wr && addr == H_CMD_ADDR && wdata[CMD_WRITE];
  assign go_read  = wr && addr == H_CMD_ADDR && wdata[CMD_READ] &&
                    !wdata[CMD_WRITE];
  // Range codes are picked by software from the tables; only codes
  // up to CODE_MAX are forwarded
  assign bad_code = (tgt_addr_q == FLOOR_ADDR ||
                     tgt_addr_q == CEILING_ADDR) &&
                    tgt_wdata_q > CODE_MAX;
  assign early_power = tgt_addr_q == POWER_ADDR &&
                       tgt_wdata_q[POWER_BIT] && !floor_set_q;
  assign refuse = go_write && (bad_code || early_power);

  always_ff @(posedge clock) begin
    if (rst) begin
      tgt_addr_q  <= 8'h00;
      tgt_wdata_q <= 8'h00;
    end else if (wr && state_q == IDLE) begin
      if (addr == H_ADDR_ADDR) begin
        tgt_addr_q <= wdata;
      end
      if (addr == H_WDATA_ADDR) begin
        tgt_wdata_q <= wdata;
      end
    end
  end

  // Transfer sequencer; commands while busy are dropped
  always_ff @(posedge clock) begin
    if (rst) begin
      state_q   <= IDLE;
      is_read_q <= 1'b0;
    end else begin
      unique case (state_q)
        IDLE: begin
          if ((go_write && !refuse) || go_read) begin
            state_q   <= ISSUE;
            is_read_q <= go_read;
          end
        end
        ISSUE:   state_q <= is_read_q ? CAPTURE : IDLE;
        CAPTURE: state_q <= IDLE;
        default: state_q <= IDLE;
      endcase
    end
  end

  assign link.addr  = tgt_addr_q;
  assign link.wdata = tgt_wdata_q;
  assign link.wr    = state_q == ISSUE && !is_read_q;
  assign link.rd    = state_q == ISSUE && is_read_q;

  always_ff @(posedge clock) begin
    if (rst) begin
      floor_set_q <= 1'b0;
    end else if (link.wr && link.addr == FLOOR_ADDR) begin
      floor_set_q <= 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      refused_q <= 1'b0;
    end else if (state_q == IDLE && go_write) begin
      refused_q <= refuse;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      result_q <= 8'h00;
    end else if (state_q == CAPTURE) begin
      result_q <= link.rdata;
    end
  end

  // Event flags; set wins over clear
  always_comb begin
    ev_set              = 3'h0;
    ev_set[HEV_DONE]    = (state_q == ISSUE && !is_read_q) ||
                          state_q == CAPTURE;
    ev_set[HEV_REFUSED] = state_q == IDLE && refuse;
    ev_set[HEV_ATTN]    = link.attention;
    ev_clr              = 3'h0;
    if (wr && addr == H_CLR_ADDR) begin
      ev_clr = wdata[2:0];
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      ev_q <= 3'h0;
    end else begin
      ev_q <= (ev_q & ~ev_clr) | ev_set;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      ev_en_q <= 3'h0;
    end else if (wr && addr == H_EN_ADDR) begin
      ev_en_q <= wdata[2:0];
    end
  end

  assign irq = |(ev_q & ev_en_q);

  always_ff @(posedge clock) begin
    if (rst) begin
      rdata_q <= 8'h00;
    end else if (rd) begin
      unique case (addr)
        H_ADDR_ADDR:  rdata_q <= tgt_addr_q;
        H_WDATA_ADDR: rdata_q <= tgt_wdata_q;
        H_STAT_ADDR:  rdata_q <= {5'h00, link.attention, refused_q,
                                  state_q != IDLE};
        H_RDATA_ADDR: rdata_q <= result_q;
        H_EV_ADDR:    rdata_q <= {5'h00, ev_q};
        H_EN_ADDR:    rdata_q <= {5'h00, ev_en_q};
        default:      rdata_q <= 8'h00;
      endcase
    end
  end

  assign rdata = rdata_q;
endmodule : inductive_host
`default_nettype wire

//--- bench/inductive_props.sv
// Link checker for the host and readout device pair
`timescale 1ns/1ps
`default_nettype none
module inductive_props
  import inductive_pkg::*;
(
  input wire logic       clock,
  input wire logic       rst,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic       wr,
  input wire logic       rd,
  input wire logic [7:0] rdata,
  input wire logic       attention
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  logic [7:0] mode_q;
  logic [7:0] cnt_q;
  logic       hi_set_q;
  logic       take_q;
  logic       held_q;

  always_ff @(posedge clock) begin
    if (rst) mode_q <= MODE_RST;
    else if (wr && addr == MODE_ADDR) mode_q <= wdata;
  end
  always_ff @(posedge clock) begin
    if (rst) hi_set_q <= 1'b0;
    else if (wr && addr == THR_HI_ADDR) hi_set_q <= 1'b1;
  end
  // Low count byte as last read, kept until the next result read
  always_ff @(posedge clock) begin
    take_q <= !rst && rd && addr == CNT_LO_ADDR;
    if (take_q) cnt_q <= rdata;
  end
  always_ff @(posedge clock) begin
    if (rst || (rd && addr == RESULT_ADDR)) held_q <= 1'b0;
    else if (take_q) held_q <= 1'b1;
  end

  wr_rd_excl_a: assert property (!(wr && rd))
    else $error("link write and read strobes together");
  wr_pulse_a: assert property (wr |=> !wr)
    else $error("link write strobe longer than one cycle");
  rd_spacing_a: assert property (rd |=> !rd [*2])
    else $error("link reads closer than three cycles");
  status_nibble_a: assert property (
    rd && addr == STATUS_ADDR |=> rdata[3:0] == 4'h0)
    else $error("status low nibble not zero");
  rdata_hold_a: assert property (!rd |=> $stable(rdata))
    else $error("read data changed without a read");
  wake_idle_a: assert property (
    rd && addr == STATUS_ADDR && mode_q[2:0] != MODE_WAKE
    |=> rdata[ST_WAKE_N])
    else $error("wake flag low while wake-up disabled");
  thr_default_a: assert property (
    rd && addr == THR_HI_ADDR && !hi_set_q |=> rdata == THR_HI_RST)
    else $error("high threshold default wrong");
  count_hold_a: assert property (
    rd && addr == CNT_LO_ADDR && held_q |=> rdata == cnt_q)
    else $error("count byte changed without result read");
  unmapped_zero_a: assert property (
    rd && addr == 8'h21 |=> rdata == 8'h00)
    else $error("unmapped read not zero");

  result_read_c: cover property (rd && addr == RESULT_ADDR);
  count_read_c: cover property (rd && addr == CNT_HI_ADDR);
  attention_c: cover property ($rose(attention));
endmodule : inductive_props
`default_nettype wire

//--- bench/tb_top.sv
// Testbench joining host controller and readout device
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import inductive_pkg::*;
  logic       clock, rst, u_wr, u_rd, irq, sensor_tick, osc_stalled;
  logic       below_floor, above_ceiling, converting;
  logic [7:0] u_addr, u_wdata, u_rdata, raw_impedance, d;
  logic [7:0] floor_code, ceiling_code;
  logic [1:0] amplitude;
  int         failures, n_checks, tick_cnt, period;
  sensor_link_if link ();
  inductive_host inductive_host_i (.clock(clock), .rst(rst),
    .link(link.host), .addr(u_addr), .wdata(u_wdata), .wr(u_wr),
    .rd(u_rd), .rdata(u_rdata), .irq(irq));
  inductive_readout inductive_readout_i (.clock(clock), .rst(rst),
    .link(link.device), .sensor_tick(sensor_tick),
    .osc_stalled(osc_stalled), .below_floor(below_floor),
    .above_ceiling(above_ceiling), .raw_impedance(raw_impedance),
    .floor_code(floor_code), .ceiling_code(ceiling_code),
    .amplitude(amplitude), .converting(converting));
  inductive_props inductive_props_i (.clock(clock), .rst(rst),
    .addr(link.addr), .wdata(link.wdata), .wr(link.wr), .rd(link.rd),
    .rdata(link.rdata), .attention(link.attention));

  initial clock = 1'b0;
  always #12.5 clock = ~clock;
  // Sensor oscillation: one tick every period clocks
  always @(posedge clock) begin
    tick_cnt <= (tick_cnt >= period - 1) ? 0 : tick_cnt + 1;
    sensor_tick <= (tick_cnt >= period - 1);
  end

  task automatic stop_test;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : stop_test
  task automatic chk(input string nm, input logic [7:0] e,
                     input logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      failures++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic hw(input logic [7:0] a, input logic [7:0] v);
    u_addr <= a;
    u_wdata <= v;
    u_wr <= 1'b1;
    @(posedge clock);
    u_wr <= 1'b0;
    @(posedge clock);
  endtask : hw
  task automatic hr(input logic [7:0] a, output logic [7:0] v);
    u_addr <= a;
    u_rd <= 1'b1;
    @(posedge clock);
    u_rd <= 1'b0;
    #1 v = u_rdata;
    @(posedge clock);
  endtask : hr
  task automatic idle;
    int i;
    logic [7:0] s;
    i = 0;
    do hr(H_STAT_ADDR, s);
    while (s[0] !== 1'b0 && ++i < 20);
    chk("busy", 8'h00, {7'h0, s[0]});
  endtask : idle
  task automatic dw(input logic [7:0] a, input logic [7:0] v);
    hw(H_ADDR_ADDR, a);
    hw(H_WDATA_ADDR, v);
    hw(H_CMD_ADDR, 8'h01);
    idle;
  endtask : dw
  task automatic dr(input logic [7:0] a, output logic [7:0] v);
    hw(H_ADDR_ADDR, a);
    hw(H_CMD_ADDR, 8'h02);
    idle;
    hr(H_RDATA_ADDR, v);
  endtask : dr
  task automatic dchk(input logic [7:0] a, input logic [7:0] e,
                      input string nm);
    dr(a, d);
    chk(nm, e, d);
  endtask : dchk
  task automatic conv;
    int i;
    i = 0;
    do dr(STATUS_ADDR, d);
    while (d[ST_READY_N] !== 1'b0 && ++i < 200);
    chk("ready", 8'h00, {7'h0, d[ST_READY_N]});
  endtask : conv
  // Latch the result of the next finished conversion
  task automatic next;
    dr(RESULT_ADDR, d);
    conv;
    dr(RESULT_ADDR, d);
  endtask : next
  task automatic cnt(input logic [23:0] e);
    dchk(CNT_HI_ADDR, e[23:16], "cnt_hi");
    dchk(CNT_LO_ADDR, e[7:0], "cnt_lo");
    dchk(CNT_MID_ADDR, e[15:8], "cnt_mid");
  endtask : cnt

  initial begin
    repeat (60000) @(posedge clock);
    failures++;
    stop_test;
  end

  initial begin
    {rst, u_wr, u_rd, u_addr, u_wdata} = {1'b1, 18'h0};
    {osc_stalled, below_floor, above_ceiling} = 3'b000;
    sensor_tick = 1'b0;
    tick_cnt = 0;
    period = 3;
    raw_impedance = 8'h50;
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    repeat (600) @(posedge clock);
    dchk(STATUS_ADDR, 8'h60, "status");
    chk("amplitude", 8'h03, {6'h0, amplitude});
    dchk(THR_HI_ADDR, THR_HI_RST, "thr_hi");
    dchk(THR_LO_ADDR, THR_LO_RST, "thr_lo");
    dchk(FLOOR_ADDR, FLOOR_RST, "floor");
    dw(POWER_ADDR, 8'h01);
    hr(H_STAT_ADDR, d);
    chk("refused", 8'h02, d & 8'h02);
    chk("converting", 8'h00, {7'h0, converting});
    dw(FLOOR_ADDR, 8'h40);
    dchk(FLOOR_ADDR, FLOOR_RST, "floor");
    dw(FLOOR_ADDR, 8'h3b);
    dw(CEILING_ADDR, 8'h12);
    chk("floor_code", 8'h3b, floor_code);
    chk("ceiling_code", 8'h12, ceiling_code);
    hw(H_EN_ADDR, 8'h01);
    dw(THR_HI_ADDR, 8'hc0);
    chk("irq", 8'h01, {7'h0, irq});
    hw(H_CLR_ADDR, 8'h01);
    chk("irq", 8'h00, {7'h0, irq});
    hw(H_EN_ADDR, 8'h00);
    dw(THR_LO_ADDR, 8'h40);
    chk("irq", 8'h00, {7'h0, irq});
    hr(H_EV_ADDR, d);
    chk("event", 8'h01, d & 8'h01);
    hw(H_EN_ADDR, 8'h01);
    chk("irq", 8'h01, {7'h0, irq});
    dw(POWER_ADDR, 8'h01);
    next;
    chk("result", 8'h50, d);
    dchk(STATUS_ADDR, 8'h60, "status");
    next;
    cnt(24'h000180);
    period <= 4;
    conv;
    cnt(24'h000180);
    next;
    cnt(24'h000200);
    dw(CONFIG_ADDR, 8'h1a);
    next;
    next;
    cnt(24'h000100);
    below_floor <= 1'b1;
    next;
    chk("clip_low", 8'h00, d);
    dchk(STATUS_ADDR, 8'h70, "status");
    below_floor <= 1'b0;
    above_ceiling <= 1'b1;
    dw(MODE_ADDR, {5'h0, MODE_WAKE});
    next;
    chk("clip_high", 8'hff, d);
    dchk(STATUS_ADDR, 8'h40, "status");
    dw(MODE_ADDR, 8'h00);
    dchk(STATUS_ADDR, 8'h60, "status");
    osc_stalled <= 1'b1;
    dr(STATUS_ADDR, d);
    chk("osc", 8'h80, d & 8'h80);
    dw(EV_EN_ADDR, 8'h04);
    chk("attention", 8'h01, {7'h0, link.attention});
    hr(H_EV_ADDR, d);
    chk("host_attn_ev", 8'h04, d & 8'h04);
    dchk(EV_STAT_ADDR, 8'h07, "dev_events");
    dw(EV_CLR_ADDR, 8'h04);
    chk("attention", 8'h00, {7'h0, link.attention});
    hr(H_STAT_ADDR, d);
    chk("host_attn", 8'h00, d & 8'h04);
    osc_stalled <= 1'b0;
    dchk(8'h21, 8'h00, "unmapped");
    hr(8'h08, d);
    chk("host_unmapped", 8'h00, d);
    stop_test;
  end
endmodule : tb_top
`default_nettype wire
